//--- hw/pulse_pattern_ctl.sv
// AXI4-Lite register block and four-group pulse pattern output with trigger and mode selection.
// What this block does
// (R1) Each group's two-bit selector picks timer channel 0, 1, 2 or 3 for codes 00, 01, 10, 11.
// (R2) The trigger select register holds group 3 at bits 7:6 down to group 0 at bits 1:0, all read/write.
// (R3) After reset every trigger selector bit reads 1, so all groups use channel 3.
// (R4) An inverted group drives its pin low for output data 1 and high for output data 0.
// (R5) Mode register bits 7 to 4 are group 3 to 0 polarity, 0 inverted, 1 direct, resetting to 1.
// (R6) In normal operation a group updates only on compare match A of its channel.
// (R7) In non-overlapping operation a group updates on compare match A or B of its channel.
// (R8) Mode register bits 3 to 0 select non-overlap for group 3 to 0, resetting to 0 for normal.
// (R9) In non-overlap mode match A copies all next-data bits, match B copies only the zero bits.
// (R10) On the selected trigger the enabled next-data bits move to output data and appear on the pins.
// (R11) When the channel's register A captures, its capture event acts as the trigger.
// (R12) Group n covers output bits 4n to 4n+3 and its settings apply to all four together.
`default_nettype none
module pulse_pattern_ctl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [pulse_pattern_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pulse_pattern_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [pulse_pattern_pkg::N_CH-1:0] cmp_a,
  input wire logic [pulse_pattern_pkg::N_CH-1:0] cmp_b,
  input wire logic [pulse_pattern_pkg::N_CH-1:0] capt_a,
  input wire logic [pulse_pattern_pkg::N_CH-1:0] capt_mode,
  output logic [pulse_pattern_pkg::OUT_W-1:0] pulse_out,
  output logic [pulse_pattern_pkg::OUT_W-1:0] pulse_en
);
  localparam int W = pulse_pattern_pkg::OUT_W;

  function automatic logic is_mapped(input logic [pulse_pattern_pkg::ADDR_W-1:0] a);
    is_mapped = (a == pulse_pattern_pkg::ADDR_TRIG_SEL) || (a == pulse_pattern_pkg::ADDR_MODE) ||
                (a == pulse_pattern_pkg::ADDR_NEXT) || (a == pulse_pattern_pkg::ADDR_ENABLE) ||
                (a == pulse_pattern_pkg::ADDR_OUT);
  endfunction : is_mapped

  logic [7:0] trig_sel_reg;
  logic [7:0] mode_reg;
  logic [W-1:0] next_data_reg;
  logic [W-1:0] enable_reg;
  logic [W-1:0] out_data_reg;
  logic [pulse_pattern_pkg::ADDR_W-1:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic aw_got_reg;
  logic w_got_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic [W-1:0] pin_reg;

  wire logic aw_hs = s_axi_awvalid & awready_reg;
  wire logic w_hs = s_axi_wvalid & wready_reg;
  wire logic ar_hs = s_axi_arvalid & arready_reg;
  wire logic do_write = aw_got_reg & w_got_reg & ~bvalid_reg;
  wire logic wr_ok = do_write & is_mapped(waddr_reg);
  wire logic [15:0] wr_lanes = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  wire logic [15:0] wr_half = wdata_reg[15:0];
  wire logic wr_trig = wr_ok & (waddr_reg == pulse_pattern_pkg::ADDR_TRIG_SEL) & wstrb_reg[0];
  wire logic wr_mode = wr_ok & (waddr_reg == pulse_pattern_pkg::ADDR_MODE) & wstrb_reg[0];
  wire logic wr_next = wr_ok & (waddr_reg == pulse_pattern_pkg::ADDR_NEXT);
  wire logic wr_en = wr_ok & (waddr_reg == pulse_pattern_pkg::ADDR_ENABLE);
  wire logic wr_out = wr_ok & (waddr_reg == pulse_pattern_pkg::ADDR_OUT);
  wire logic [W-1:0] next_data_next = wr_next ? (next_data_reg & ~wr_lanes) | (wr_half & wr_lanes) : next_data_reg;
  wire logic [W-1:0] enable_next = wr_en ? (enable_reg & ~wr_lanes) | (wr_half & wr_lanes) : enable_reg;
  // A software write to output data lands first; a trigger in the same cycle then overrides enabled bits.
  wire logic [W-1:0] out_base = wr_out ? (out_data_reg & ~wr_lanes) | (wr_half & wr_lanes) : out_data_reg;
  wire logic [W-1:0] out_data_next;
  wire logic [W-1:0] pin_next;
  wire logic [31:0] rd_mux =
    (s_axi_araddr == pulse_pattern_pkg::ADDR_TRIG_SEL) ? {24'h000000, trig_sel_reg} :
    (s_axi_araddr == pulse_pattern_pkg::ADDR_MODE) ? {24'h000000, mode_reg} :
    (s_axi_araddr == pulse_pattern_pkg::ADDR_NEXT) ? {16'h0000, next_data_reg} :
    (s_axi_araddr == pulse_pattern_pkg::ADDR_ENABLE) ? {16'h0000, enable_reg} :
    (s_axi_araddr == pulse_pattern_pkg::ADDR_OUT) ? {16'h0000, out_data_reg} : 32'h00000000;

  genvar gi;
  generate
    for (gi = 0; gi < pulse_pattern_pkg::N_GRP; gi++) begin : g_grp
      group_ctl_if bus ();
      assign bus.sel = trig_sel_reg[gi*pulse_pattern_pkg::SEL_W +: pulse_pattern_pkg::SEL_W]; // R2
      assign bus.nov = mode_reg[pulse_pattern_pkg::NOV_LSB + gi]; // R8
      assign bus.pol = mode_reg[pulse_pattern_pkg::POL_LSB + gi]; // R5
      assign bus.cmp_a = cmp_a;
      assign bus.cmp_b = cmp_b;
      assign bus.capt_a = capt_a;
      assign bus.capt_mode = capt_mode;
      assign bus.next_data_latch = next_data_reg[gi*pulse_pattern_pkg::GRP_W +: pulse_pattern_pkg::GRP_W]; // R12
      assign bus.en = enable_reg[gi*pulse_pattern_pkg::GRP_W +: pulse_pattern_pkg::GRP_W];
      assign bus.output_data_latch = out_base[gi*pulse_pattern_pkg::GRP_W +: pulse_pattern_pkg::GRP_W];
      assign out_data_next[gi*pulse_pattern_pkg::GRP_W +: pulse_pattern_pkg::GRP_W] = bus.output_data_latch_next;
      assign pin_next[gi*pulse_pattern_pkg::GRP_W +: pulse_pattern_pkg::GRP_W] = bus.pin_next;
      group_update u_grp (
        .aclk(aclk),
        .aresetn(aresetn),
        .g(bus.grp)
      );
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_sel_reg <= pulse_pattern_pkg::TRIG_SEL_RST; // R3
      mode_reg <= pulse_pattern_pkg::MODE_RST; // R5 R8
      next_data_reg <= pulse_pattern_pkg::DATA_RST;
      enable_reg <= pulse_pattern_pkg::DATA_RST;
      out_data_reg <= pulse_pattern_pkg::DATA_RST;
      pin_reg <= pulse_pattern_pkg::DATA_RST;
    end else begin
      if (wr_trig) begin
        trig_sel_reg <= wdata_reg[7:0]; // R2
      end
      if (wr_mode) begin
        mode_reg <= wdata_reg[7:0];
      end
      next_data_reg <= next_data_next;
      enable_reg <= enable_next;
      out_data_reg <= out_data_next; // R10
      pin_reg <= pin_next; // R4
    end
  end

  // The bus ports are registered, so each channel accepts at most one item per response.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= pulse_pattern_pkg::RESP_OKAY;
      waddr_reg <= '0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else begin
      if (aw_hs) begin
        waddr_reg <= s_axi_awaddr;
        aw_got_reg <= 1'b1;
        awready_reg <= 1'b0;
      end
      if (w_hs) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        w_got_reg <= 1'b1;
        wready_reg <= 1'b0;
      end
      if (do_write) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_ok ? pulse_pattern_pkg::RESP_OKAY : pulse_pattern_pkg::RESP_SLVERR;
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rresp_reg <= pulse_pattern_pkg::RESP_OKAY;
      rdata_reg <= 32'h00000000;
    end else if (ar_hs) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= is_mapped(s_axi_araddr) ? pulse_pattern_pkg::RESP_OKAY : pulse_pattern_pkg::RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign pulse_out = pin_reg;
  assign pulse_en = enable_reg;

  a_reset_values: assert property (@(posedge aclk) disable iff (!aresetn) // R3
    $past(!aresetn) |-> (trig_sel_reg == pulse_pattern_pkg::TRIG_SEL_RST && mode_reg == pulse_pattern_pkg::MODE_RST))
    else $error("control registers not at reset values after reset");
  a_pin_polarity: assert property (@(posedge aclk) disable iff (!aresetn) // R4
    $past(aresetn) |-> pulse_out[3:0] == ($past(mode_reg[4]) ? out_data_reg[3:0] : ~out_data_reg[3:0]))
    else $error("group 0 pin polarity does not match its mode bit");
  a_sel_write: assert property (@(posedge aclk) disable iff (!aresetn) // R2
    wr_trig |=> trig_sel_reg == $past(wdata_reg[7:0]))
    else $error("trigger select write not stored");
  a_grp3_channel: assert property (@(posedge aclk) disable iff (!aresetn) // R1 R12
    (trig_sel_reg[7:6] == 2'h0 && cmp_a[0] && !capt_mode[0] && enable_reg[15:12] == 4'hF && !wr_out)
      |=> out_data_reg[15:12] == $past(next_data_reg[15:12]))
    else $error("group 3 did not load on channel 0 compare match A");
  a_read_latency: assert property (@(posedge aclk) disable iff (!aresetn) // R2
    ar_hs |=> rvalid_reg && !arready_reg)
    else $error("read answer not one cycle after address");
endmodule : pulse_pattern_ctl
`default_nettype wire

//--- hw/pulse_pattern_pkg.sv
// Register map, field layout and reset values for the pulse pattern trigger and mode control.
`default_nettype none
package pulse_pattern_pkg;
  localparam int N_GRP = 4;
  localparam int GRP_W = 4;
  localparam int N_CH = 4;
  localparam int SEL_W = 2;
  localparam int OUT_W = N_GRP * GRP_W;
  localparam int POL_LSB = 4;
  localparam int NOV_LSB = 0;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_TRIG_SEL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_MODE = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_NEXT = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_ENABLE = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_OUT = 8'h10;
  localparam logic [7:0] TRIG_SEL_RST = 8'hFF;
  localparam logic [7:0] MODE_RST = 8'hF0;
  localparam logic [OUT_W-1:0] DATA_RST = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pulse_pattern_pkg
`default_nettype wire

//--- hw/group_ctl_if.sv
// Bundle between the register block and one output group's update logic.
`default_nettype none
interface group_ctl_if;
  logic [pulse_pattern_pkg::SEL_W-1:0] sel;
  logic nov;
  logic pol;
  logic [pulse_pattern_pkg::N_CH-1:0] cmp_a;
  logic [pulse_pattern_pkg::N_CH-1:0] cmp_b;
  logic [pulse_pattern_pkg::N_CH-1:0] capt_a;
  logic [pulse_pattern_pkg::N_CH-1:0] capt_mode;
  logic [pulse_pattern_pkg::GRP_W-1:0] next_data_latch;
  logic [pulse_pattern_pkg::GRP_W-1:0] en;
  logic [pulse_pattern_pkg::GRP_W-1:0] output_data_latch;
  logic [pulse_pattern_pkg::GRP_W-1:0] output_data_latch_next;
  logic [pulse_pattern_pkg::GRP_W-1:0] pin_next;
  modport grp (input sel, nov, pol, cmp_a, cmp_b, capt_a, capt_mode, next_data_latch, en, output_data_latch, output output_data_latch_next, pin_next);
  modport ctl (output sel, nov, pol, cmp_a, cmp_b, capt_a, capt_mode, next_data_latch, en, output_data_latch, input output_data_latch_next, pin_next);
endinterface : group_ctl_if
`default_nettype wire

//--- hw/group_update.sv
// Trigger selection and output-data update for one group of four pulse outputs.
`default_nettype none
module group_update (
  input wire logic aclk,
  input wire logic aresetn,
  group_ctl_if.grp g
);
  wire logic trig_a;
  wire logic trig_b;
  wire logic [pulse_pattern_pkg::GRP_W-1:0] load_all;
  wire logic [pulse_pattern_pkg::GRP_W-1:0] clear_zero;

  // A channel whose register A captures gives its capture event in place of compare match A.
  assign trig_a = g.capt_mode[g.sel] ? g.capt_a[g.sel] : g.cmp_a[g.sel]; // R1 R11
  assign trig_b = g.nov & g.cmp_b[g.sel]; // R6 R7 R8
  assign load_all = {pulse_pattern_pkg::GRP_W{trig_a}} & g.en; // R10 R12
  assign clear_zero = {pulse_pattern_pkg::GRP_W{trig_b}} & g.en & ~g.next_data_latch; // R9
  assign g.output_data_latch_next = (g.output_data_latch & ~load_all & ~clear_zero) | (g.next_data_latch & load_all); // R9 R10
  assign g.pin_next = g.pol ? g.output_data_latch_next : ~g.output_data_latch_next; // R4

  a_sel_channel: assert property (@(posedge aclk) disable iff (!aresetn) // R1
    (!g.capt_mode[g.sel] && g.cmp_a[g.sel] && g.en != 4'h0) |-> (g.output_data_latch_next & g.en) == (g.next_data_latch & g.en))
    else $error("selected channel compare match A did not load the group");
  a_normal_hold: assert property (@(posedge aclk) disable iff (!aresetn) // R6
    (!g.nov && !trig_a) |-> g.output_data_latch_next == g.output_data_latch)
    else $error("normal mode group changed without compare match A");
  a_nonov_clear: assert property (@(posedge aclk) disable iff (!aresetn) // R7
    (g.nov && !trig_a && g.cmp_b[g.sel]) |-> g.output_data_latch_next == (g.output_data_latch & ~(g.en & ~g.next_data_latch)))
    else $error("compare match B did not pass only zero bits");
  a_capture_trig: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    (g.capt_mode[g.sel] && g.capt_a[g.sel]) |-> (g.output_data_latch_next & g.en) == (g.next_data_latch & g.en))
    else $error("input capture did not trigger the group");
  a_disabled_hold: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    1'b1 |-> (g.output_data_latch_next & ~g.en) == (g.output_data_latch & ~g.en))
    else $error("disabled bit was changed by a trigger");
endmodule : group_update
`default_nettype wire

//--- bench/timer_model.sv
// Behavioural timer unit that issues compare match and capture pulses on command.
`default_nettype none
module timer_model (
  input wire logic aclk,
  output var logic [pulse_pattern_pkg::N_CH-1:0] cmp_a,
  output var logic [pulse_pattern_pkg::N_CH-1:0] cmp_b,
  output var logic [pulse_pattern_pkg::N_CH-1:0] capt_a,
  output var logic [pulse_pattern_pkg::N_CH-1:0] capt_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmp_a = 4'h0;
    cmp_b = 4'h0;
    capt_a = 4'h0;
    capt_mode = 4'h0;
  end
  // Events last exactly one cycle, as a real timer strobe does.
  task fire(input int ch, input int kind);
    @(posedge aclk);
    case (kind)
      0: cmp_a[ch] <= 1'b1;
      1: cmp_b[ch] <= 1'b1;
      default: capt_a[ch] <= 1'b1;
    endcase
    @(posedge aclk);
    cmp_a <= 4'h0;
    cmp_b <= 4'h0;
    capt_a <= 4'h0;
  endtask : fire
  task set_capt(input logic [3:0] m);
    @(posedge aclk);
    capt_mode <= m;
  endtask : set_capt
endmodule : timer_model
`default_nettype wire

//--- bench/pulse_pattern_ctl_tb.sv
// Self-checking bench for the pulse pattern trigger and mode control.
`default_nettype none
module pulse_pattern_ctl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] A_SEL = pulse_pattern_pkg::ADDR_TRIG_SEL;
  localparam logic [7:0] A_MODE = pulse_pattern_pkg::ADDR_MODE;
  localparam logic [7:0] A_NEXT = pulse_pattern_pkg::ADDR_NEXT;
  localparam logic [7:0] A_EN = pulse_pattern_pkg::ADDR_ENABLE;
  localparam logic [1:0] OK = pulse_pattern_pkg::RESP_OKAY;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] cmp_a, cmp_b, capt_a, capt_mode;
  logic [15:0] pulse_out, pulse_en, e;
  int err_count = 0;
  int n_compared = 0;
  initial forever #5 aclk = ~aclk;
  pulse_pattern_ctl pulse_pattern_ctl_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cmp_a(cmp_a), .cmp_b(cmp_b), .capt_a(capt_a), .capt_mode(capt_mode), .pulse_out(pulse_out),
    .pulse_en(pulse_en));
  timer_model timer_model_i (.aclk(aclk), .cmp_a(cmp_a), .cmp_b(cmp_b), .capt_a(capt_a), .capt_mode(capt_mode));
  task results;
    if (err_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task hung;
    err_count++;
    $display("ERROR %0t: bus answer never came", $time);
    results();
  endtask : hung
  task wr(input logic [7:0] a, input logic [31:0] d);
    bit done;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 50 && !done; i++) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        chk(32'(bresp), 32'(OK));
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) hung();
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bit done;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 50 && !done; i++) begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        chk(rdata, d);
        chk(32'(rresp), 32'(r));
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) hung();
  endtask : rd
  // Two edges let a mode write reach the registered pins before they are judged.
  task pins(input logic [15:0] o, input logic [15:0] en);
    repeat (2) @(posedge aclk);
    #1;
    chk(32'(pulse_out), 32'(o));
    chk(32'(pulse_en), 32'(en));
  endtask : pins
  initial begin
    e = 16'h0000;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(A_SEL, 32'h000000FF, OK);
    rd(A_MODE, 32'h000000F0, OK);
    rd(8'h20, 32'h00000000, pulse_pattern_pkg::RESP_SLVERR);
    pins(16'h0000, 16'h0000);
    // Each group gets a different channel, so a wrong field position moves the wrong nibble.
    wr(A_SEL, 32'h0000001B);
    rd(A_SEL, 32'h0000001B, OK);
    wr(A_EN, 32'h0000FFFF);
    wr(A_NEXT, 32'h0000FFFF);
    for (int c = 0; c < 4; c++) begin
      timer_model_i.fire(c, 0);
      e = e | (16'hF << (4 * (3 - c)));
      pins(e, 16'hFFFF);
    end
    wr(A_NEXT, 32'h00000000);
    timer_model_i.fire(3, 1);
    pins(16'hFFFF, 16'hFFFF);
    wr(A_MODE, 32'h000000F1);
    rd(A_MODE, 32'h000000F1, OK);
    timer_model_i.fire(3, 1);
    pins(16'hFFF0, 16'hFFFF);
    wr(A_NEXT, 32'h00000005);
    timer_model_i.fire(3, 1);
    pins(16'hFFF0, 16'hFFFF);
    timer_model_i.fire(3, 0);
    pins(16'hFFF5, 16'hFFFF);
    wr(A_MODE, 32'h000000E1);
    pins(16'hFFFA, 16'hFFFF);
    timer_model_i.set_capt(4'h8);
    wr(A_NEXT, 32'h00000000);
    timer_model_i.fire(3, 0);
    pins(16'hFFFA, 16'hFFFF);
    timer_model_i.fire(3, 2);
    pins(16'hFFFF, 16'hFFFF);
    timer_model_i.set_capt(4'h0);
    wr(A_EN, 32'h00000FFF);
    timer_model_i.fire(0, 0);
    pins(16'hFFFF, 16'h0FFF);
    wr(pulse_pattern_pkg::ADDR_OUT, 32'h00001234);
    rd(pulse_pattern_pkg::ADDR_OUT, 32'h00001234, OK);
    rd(A_EN, 32'h00000FFF, OK);
    pins(16'h123B, 16'h0FFF);
    results();
  end
endmodule : pulse_pattern_ctl_tb
`default_nettype wire
